/* pkg/dme_pkg.sv */
// Function
// [RQ1] Signedness control applies per cycle to operands
// [RQ2] Accumulator adds or subtracts per cycle control
// [RQ3] Operands load in parallel or serially, switchable
// [RQ4] Plain multiplier outputs A times B only
// [RQ5] Multiplier input, pipeline, output stages individually enabled
// [RQ6] Dual element outputs sum or difference of products
// [RQ7] Dual element stages separately enabled, latency tradeoff
// [RQ8] Full width products, one guard bit on sum
package dme_pkg;

  // Datapath widths
  localparam int OPW = 9;             // Operand width
  localparam int PW = 2 * OPW;        // Full product width
  localparam int SW = PW + 1;         // Sum width with guard bit
  localparam int ACCW = 32;           // Accumulator width
  localparam int FIFO_DEPTH = 16;     // Result buffer depth

  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;   // Stage enables, modes
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;    // Write-only commands
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;   // Buffer fill, phase
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h0C;    // Accumulator value

  // Control field positions
  localparam int CTRL_MUL_EN_LSB = 0;   // 3 bits: input, pipe, output
  localparam int CTRL_DUAL_EN_LSB = 4;  // 3 bits: input, pipe, output
  localparam int CTRL_SERIAL_BIT = 8;   // 1 = serial operand loading
  localparam int CTRL_ACC_EN_BIT = 9;   // 1 = accumulate dual results
  localparam int CMD_ACC_CLR_BIT = 0;   // 1 = clear accumulator
  localparam int STAT_PHASE_LSB = 8;    // 2 bits serial phase
  localparam int STAGES = 3;
  localparam logic [STAGES-1:0] EN_RESET = 3'h0;

  // Operand set as taken from the fabric
  typedef struct packed {
    logic [OPW-1:0] a0;
    logic [OPW-1:0] b0;
    logic [OPW-1:0] a1;
    logic [OPW-1:0] b1;
    logic sgn;       // Operands signed
    logic sub;       // Dual element subtracts
    logic acc_sub;   // Accumulator subtracts
  } dme_op_s;

  // Control register contents
  typedef struct packed {
    logic [STAGES-1:0] mul_en;
    logic [STAGES-1:0] dual_en;
    logic serial;
    logic acc_en;
  } dme_ctrl_s;

  localparam dme_ctrl_s CTRL_RESET = '{EN_RESET, EN_RESET, 1'b0, 1'b0};

  // Dual element after multiply
  typedef struct packed {
    logic [PW-1:0] p0;
    logic [PW-1:0] p1;
    logic sgn;
    logic sub;
    logic acc_sub;
  } dme_prod_s;

  // Dual element after add or subtract
  typedef struct packed {
    logic [SW-1:0] sum;
    logic neg_ok;    // Sum is two's complement
    logic acc_sub;
  } dme_sum_s;

  // Buffered result word
  typedef struct packed {
    logic [SW-1:0] sum;
    logic [ACCW-1:0] acc;
  } dme_res_s;

endpackage : dme_pkg

/* design/dme_fifo.sv */
`timescale 1ns/100ps
module dme_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  // Fill level
  output logic [$clog2(DEPTH):0] o_count
);

  localparam int AW = $clog2(DEPTH);

  // Storage and pointers
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next;
  logic [AW-1:0] rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // Honest flags straight from the count
  assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_reg];
  assign o_count = cnt_reg;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Next pointers, count and storage
  always_comb
  begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push)
    begin
      mem_next[wr_reg] = i_in_data;
      wr_next = wr_reg + 1'b1;
    end
    if (pop)
      rd_next = rd_reg + 1'b1;
    // Simultaneous push and pop leave the count alone
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end

  // Register only
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      mem_reg <= mem_next;
    end
  end

endmodule : dme_fifo

/* design/dme_top.sv */
`timescale 1ns/100ps
module dme_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Register port
  input wire logic [dme_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dme_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [dme_pkg::DATA_W-1:0] o_rdata,
  // Operand stream
  input wire logic i_op_valid,
  input wire dme_pkg::dme_op_s i_op,
  output logic o_op_ready,
  // Plain multiplier result
  output logic o_mul_valid,
  output logic [dme_pkg::PW-1:0] o_mul_prod,
  // Dual element result stream
  output logic o_res_valid,
  output dme_pkg::dme_res_s o_res,
  input wire logic i_res_ready
);

  localparam int OPW = dme_pkg::OPW;
  localparam int PW = dme_pkg::PW;
  localparam int SW = dme_pkg::SW;
  localparam int ACCW = dme_pkg::ACCW;
  localparam int DW = dme_pkg::DATA_W;
  localparam int CW = $clog2(dme_pkg::FIFO_DEPTH) + 1;

  // Full width product, sign handled by extension
  function automatic logic [PW-1:0] mul(input logic [OPW-1:0] a,
                                        input logic [OPW-1:0] b,
                                        input logic s);
    logic signed [OPW:0] ea;
    logic signed [OPW:0] eb;
    logic signed [2*OPW+1:0] p;
    ea = {s & a[OPW-1], a};  // RQ1
    eb = {s & b[OPW-1], b};  // RQ1
    p = ea * eb;
    mul = p[PW-1:0];  // RQ8
  endfunction : mul

  // Product widened by the guard bit
  function automatic logic [SW-1:0] ext(input logic [PW-1:0] p,
                                        input logic s);
    ext = {s & p[PW-1], p};  // RQ8
  endfunction : ext

  // Control and command state
  dme_pkg::dme_ctrl_s ctrl_reg, ctrl_next;
  logic [DW-1:0] rdata_reg, rdata_next;
  logic acc_clr;

  // Serial loading state
  logic [1:0] phase_reg, phase_next;
  dme_pkg::dme_op_s sbuf_reg, sbuf_next;
  dme_pkg::dme_op_s set;
  logic set_valid;

  // Pipeline state, all stages share one advance
  logic adv;
  dme_pkg::dme_op_s m0_reg, m0_next, m0;
  logic m0_v_reg, m0_v_next, m0_v;
  logic [PW-1:0] m1_reg, m1_next, m1, m1_in;
  logic m1_v_reg, m1_v_next, m1_v;
  logic [PW-1:0] m2_reg, m2_next;
  logic m2_v_reg, m2_v_next;
  dme_pkg::dme_op_s d0_reg, d0_next, d0;
  logic d0_v_reg, d0_v_next, d0_v;
  dme_pkg::dme_prod_s d1_reg, d1_next, d1, d1_in;
  logic d1_v_reg, d1_v_next, d1_v;
  dme_pkg::dme_sum_s d2_reg, d2_next, d2, d2_in;
  logic d2_v_reg, d2_v_next, d2_v;

  // Accumulator and buffer
  logic [ACCW-1:0] acc_reg, acc_next;
  logic [ACCW-1:0] acc_base, acc_term;
  logic push;
  dme_pkg::dme_res_s fifo_in;
  logic [CW-1:0] fifo_count;

  // Register writes and reads
  always_comb
  begin
    ctrl_next = ctrl_reg;
    rdata_next = '0;
    acc_clr = 1'b0;
    if (i_wr)
    begin
      case (i_addr)
        dme_pkg::OFS_CTRL:
        begin
          ctrl_next.mul_en = i_wdata[dme_pkg::CTRL_MUL_EN_LSB +: 3];
          ctrl_next.dual_en = i_wdata[dme_pkg::CTRL_DUAL_EN_LSB +: 3];
          ctrl_next.serial = i_wdata[dme_pkg::CTRL_SERIAL_BIT];  // RQ3
          ctrl_next.acc_en = i_wdata[dme_pkg::CTRL_ACC_EN_BIT];
        end
        dme_pkg::OFS_CMD:
          acc_clr = i_wdata[dme_pkg::CMD_ACC_CLR_BIT];
        // Writes elsewhere are ignored
        default: ;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        dme_pkg::OFS_CTRL:
        begin
          rdata_next[dme_pkg::CTRL_MUL_EN_LSB +: 3] = ctrl_reg.mul_en;
          rdata_next[dme_pkg::CTRL_DUAL_EN_LSB +: 3] = ctrl_reg.dual_en;
          rdata_next[dme_pkg::CTRL_SERIAL_BIT] = ctrl_reg.serial;
          rdata_next[dme_pkg::CTRL_ACC_EN_BIT] = ctrl_reg.acc_en;
        end
        dme_pkg::OFS_STAT:
        begin
          rdata_next[CW-1:0] = fifo_count;
          rdata_next[dme_pkg::STAT_PHASE_LSB +: 2] = phase_reg;
        end
        dme_pkg::OFS_ACC:
          rdata_next = acc_reg;
        // Command and unmapped addresses read zero
        default: rdata_next = '0;
      endcase
    end
  end

  // Serial phase counts words a0, b0, a1, b1
  always_comb
  begin
    phase_next = phase_reg;
    sbuf_next = sbuf_reg;
    set = i_op;
    set_valid = i_op_valid;  // RQ3
    if (!ctrl_reg.serial)
      phase_next = 2'h0;  // RQ3
    else
    begin
      // Word rides on the a0 lane; controls come with the last word
      set = sbuf_reg;
      set.b1 = i_op.a0;
      set.sgn = i_op.sgn;
      set.sub = i_op.sub;
      set.acc_sub = i_op.acc_sub;
      set_valid = i_op_valid && (phase_reg == 2'h3);  // RQ3
      if (i_op_valid && adv)
      begin
        phase_next = phase_reg + 2'h1;
        case (phase_reg)
          2'h0: sbuf_next.a0 = i_op.a0;
          2'h1: sbuf_next.b0 = i_op.a0;
          2'h2: sbuf_next.a1 = i_op.a0;
          default: ;
        endcase
      end
    end
  end

  // Whole datapath holds while the buffer is full
  logic fifo_ready_w;
  assign adv = o_op_ready;
  assign o_op_ready = fifo_ready_w;

  // Plain multiplier stages, each bypassed when disabled
  always_comb
  begin
    m0 = ctrl_reg.mul_en[0] ? m0_reg : set;  // RQ5
    m0_v = ctrl_reg.mul_en[0] ? m0_v_reg : set_valid;  // RQ5
    m1_in = mul(m0.a0, m0.b0, m0.sgn);  // RQ4
    m1 = ctrl_reg.mul_en[1] ? m1_reg : m1_in;  // RQ5
    m1_v = ctrl_reg.mul_en[1] ? m1_v_reg : m0_v;  // RQ5
    o_mul_prod = ctrl_reg.mul_en[2] ? m2_reg : m1;  // RQ5
    o_mul_valid = ctrl_reg.mul_en[2] ? m2_v_reg : m1_v;  // RQ5
    m0_next = adv ? set : m0_reg;
    m0_v_next = adv ? set_valid : m0_v_reg;
    m1_next = adv ? m1_in : m1_reg;
    m1_v_next = adv ? m0_v : m1_v_reg;
    m2_next = adv ? m1 : m2_reg;
    m2_v_next = adv ? m1_v : m2_v_reg;
  end

  // Dual product stages, each bypassed when disabled
  always_comb
  begin
    d0 = ctrl_reg.dual_en[0] ? d0_reg : set;  // RQ7
    d0_v = ctrl_reg.dual_en[0] ? d0_v_reg : set_valid;  // RQ7
    d1_in.p0 = mul(d0.a0, d0.b0, d0.sgn);  // RQ6
    d1_in.p1 = mul(d0.a1, d0.b1, d0.sgn);  // RQ6
    d1_in.sgn = d0.sgn;
    d1_in.sub = d0.sub;
    d1_in.acc_sub = d0.acc_sub;
    d1 = ctrl_reg.dual_en[1] ? d1_reg : d1_in;  // RQ7
    d1_v = ctrl_reg.dual_en[1] ? d1_v_reg : d0_v;  // RQ7
    d2_in.sum = d1.sub ? ext(d1.p0, d1.sgn) - ext(d1.p1, d1.sgn)
                       : ext(d1.p0, d1.sgn) + ext(d1.p1, d1.sgn);  // RQ6
    d2_in.neg_ok = d1.sgn | d1.sub;
    d2_in.acc_sub = d1.acc_sub;
    d2 = ctrl_reg.dual_en[2] ? d2_reg : d2_in;  // RQ7
    d2_v = ctrl_reg.dual_en[2] ? d2_v_reg : d1_v;  // RQ7
    d0_next = adv ? set : d0_reg;
    d0_v_next = adv ? set_valid : d0_v_reg;
    d1_next = adv ? d1_in : d1_reg;
    d1_v_next = adv ? d0_v : d1_v_reg;
    d2_next = adv ? d2_in : d2_reg;
    d2_v_next = adv ? d1_v : d2_v_reg;
  end

  // Accumulate as each dual result enters the buffer
  always_comb
  begin
    acc_base = acc_clr ? '0 : acc_reg;
    acc_term = {{(ACCW-SW){d2.neg_ok & d2.sum[SW-1]}}, d2.sum};
    acc_next = acc_base;
    if (push && ctrl_reg.acc_en)
      acc_next = d2.acc_sub ? acc_base - acc_term
                            : acc_base + acc_term;  // RQ2
    fifo_in.sum = d2.sum;
    fifo_in.acc = acc_next;
  end

  assign push = d2_v && adv;

  // All state registers
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_reg <= dme_pkg::CTRL_RESET;
      rdata_reg <= '0;
      phase_reg <= 2'h0;
      sbuf_reg <= '0;
      m0_reg <= '0;
      m0_v_reg <= 1'b0;
      m1_reg <= '0;
      m1_v_reg <= 1'b0;
      m2_reg <= '0;
      m2_v_reg <= 1'b0;
      d0_reg <= '0;
      d0_v_reg <= 1'b0;
      d1_reg <= '0;
      d1_v_reg <= 1'b0;
      d2_reg <= '0;
      d2_v_reg <= 1'b0;
      acc_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      phase_reg <= phase_next;
      sbuf_reg <= sbuf_next;
      m0_reg <= m0_next;
      m0_v_reg <= m0_v_next;
      m1_reg <= m1_next;
      m1_v_reg <= m1_v_next;
      m2_reg <= m2_next;
      m2_v_reg <= m2_v_next;
      d0_reg <= d0_next;
      d0_v_reg <= d0_v_next;
      d1_reg <= d1_next;
      d1_v_reg <= d1_v_next;
      d2_reg <= d2_next;
      d2_v_reg <= d2_v_next;
      acc_reg <= acc_next;
    end
  end

  assign o_rdata = rdata_reg;

  // Result buffer; its ready stalls the whole datapath
  dme_fifo #(
    .WIDTH($bits(dme_pkg::dme_res_s)),
    .DEPTH(dme_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_in_valid(d2_v),
    .i_in_data(fifo_in),
    .o_in_ready(fifo_ready_w),
    .o_out_valid(o_res_valid),
    .o_out_data(o_res),
    .i_out_ready(i_res_ready),
    .o_count(fifo_count)
  );

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  chk_signed_plain_multiplier_element: assert property (  // RQ1
    set_valid && ctrl_reg.mul_en == 3'h0 && set.sgn |->
      o_mul_prod == PW'($signed(set.a0) * $signed(set.b0)))
    else $error("signed product wrong");

  chk_plain_plain_multiplier_element: assert property (  // RQ4
    set_valid && ctrl_reg.mul_en == 3'h0 && !set.sgn |->
      o_mul_valid && o_mul_prod == PW'(set.a0 * set.b0))
    else $error("unsigned product wrong");

  chk_plain_multiplier_element_latency: assert property (  // RQ5
    set_valid && adv && ctrl_reg.mul_en == 3'h1 && !set.sgn
      ##1 $stable(ctrl_reg) |->
      o_mul_valid && o_mul_prod == PW'($past(set.a0) * $past(set.b0)))
    else $error("one stage multiplier latency wrong");

  chk_acc_add: assert property (  // RQ2
    push && ctrl_reg.acc_en && !acc_clr && !d2.acc_sub |=>
      acc_reg == $past(acc_reg) + $past(acc_term))
    else $error("accumulator add wrong");

  chk_acc_sub: assert property (  // RQ2
    push && ctrl_reg.acc_en && !acc_clr && d2.acc_sub |=>
      acc_reg == $past(acc_reg) - $past(acc_term))
    else $error("accumulator subtract wrong");

  chk_serial_group: assert property (  // RQ3
    ctrl_reg.serial && i_op_valid && adv && phase_reg != 2'h3 |->
      !set_valid ##1 phase_reg == $past(phase_reg) + 2'h1)
    else $error("serial word not counted");

  chk_parallel_take: assert property (  // RQ3
    !ctrl_reg.serial |-> set_valid == i_op_valid && phase_reg == 2'h0
      || $past(ctrl_reg.serial))
    else $error("parallel load not immediate");

  chk_dual_sum: assert property (  // RQ6
    set_valid && ctrl_reg.dual_en == 3'h0 && !set.sgn && !set.sub |->
      d2_v && d2.sum == SW'(set.a0 * set.b0) + SW'(set.a1 * set.b1))
    else $error("dual sum wrong");

  chk_dual_latency: assert property (  // RQ7
    set_valid && adv && ctrl_reg.dual_en == 3'h7 ##1 adv ##1 adv
      ##1 $stable(ctrl_reg) |-> d2_v)
    else $error("three stage dual latency wrong");

  chk_full_width: assert property (  // RQ8
    set_valid && ctrl_reg.dual_en == 3'h0 && !set.sgn && set.sub |->
      d2.sum == SW'(set.a0 * set.b0) - SW'(set.a1 * set.b1))
    else $error("dual difference wrong");

endmodule : dme_top

/* tb/dme_fab_sink.sv */
`timescale 1ns/100ps
module dme_fab_sink (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Result stream
  input wire logic i_valid,
  input wire dme_pkg::dme_res_s i_res,
  output logic o_ready,
  // Stall request
  input wire logic i_stall
);
  // Words taken, oldest first
  dme_pkg::dme_res_s got_q[$];

  // Ready lags stall by a clock, as a registered fabric sink would
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      o_ready <= 1'b0;
    else
      o_ready <= !i_stall;
  end

  // Capture on the accepting edge only
  always @(posedge i_clock)
  begin
    if (i_valid && o_ready)
      got_q.push_back(i_res);
  end
endmodule : dme_fab_sink

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic i_op_valid = 1'b0;
  dme_pkg::dme_op_s i_op = '0;
  logic o_op_ready, o_mul_valid, o_res_valid, res_ready;
  logic [17:0] o_mul_prod;
  dme_pkg::dme_res_s o_res;
  logic stall = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] acc_m;  // Accumulator model
  logic [31:0] rd_v;

  dme_top dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_op_valid(i_op_valid), .i_op(i_op), .o_op_ready(o_op_ready),
    .o_mul_valid(o_mul_valid), .o_mul_prod(o_mul_prod),
    .o_res_valid(o_res_valid), .o_res(o_res), .i_res_ready(res_ready));
  dme_fab_sink fab (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_valid(o_res_valid), .i_res(o_res), .o_ready(res_ready),
    .i_stall(stall));

  // Clock and hang guard
  initial
  begin
    forever #4 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One edge passes after the strobe so a following write never
  // assigns the strobe twice in one time step
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    rd_v = o_rdata;
    @(posedge i_clock);
  endtask : rd

  // Holds valid until an edge with ready high; ready only moves on edges
  task send(input dme_pkg::dme_op_s op);
    logic ok;
    i_op <= op;
    i_op_valid <= 1'b1;
    do
    begin
      @(negedge i_clock);
      ok = o_op_ready;
      @(posedge i_clock);
    end while (!ok);
  endtask : send

  function automatic logic [17:0] ext(input logic [8:0] v, input logic s);
    return s ? {{9{v[8]}}, v} : {9'h000, v};
  endfunction : ext

  function automatic logic [18:0] dsum(input dme_pkg::dme_op_s o);
    logic [17:0] p0, p1;
    logic [18:0] e0, e1;
    p0 = ext(o.a0, o.sgn) * ext(o.b0, o.sgn);
    p1 = ext(o.a1, o.sgn) * ext(o.b1, o.sgn);
    e0 = o.sgn ? {p0[17], p0} : {1'b0, p0};
    e1 = o.sgn ? {p1[17], p1} : {1'b0, p1};
    return o.sub ? e0 - e1 : e0 + e1;
  endfunction : dsum

  function automatic void acc_step(input dme_pkg::dme_op_s o);
    logic [18:0] s;
    logic [31:0] x;
    s = dsum(o);
    x = (o.sgn || o.sub) ? {{13{s[18]}}, s} : {13'h0, s};
    acc_m = o.acc_sub ? acc_m - x : acc_m + x;
  endfunction : acc_step

  // Reset values, unmapped and write-only places
  task t_regs();
    rd(8'h00);
    chk(rd_v, 32'h0, "ctrl reset");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk(rd_v, 32'h0, "unmapped");
    rd(8'h04);
    chk(rd_v, 32'h0, "cmd read");
    rd(8'h08);
    chk(rd_v, 32'h0, "stat idle");
  endtask : t_regs

  // Latency equals enabled stage count; sign switches every two ops
  task t_mul();
    logic [2:0] cfg[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h7};
    int n;
    logic [17:0] p;
    dme_pkg::dme_op_s o;
    foreach (cfg[i])
    begin
      wr(8'h00, {29'h0, cfg[i]});
      n = cfg[i][0] + cfg[i][1] + cfg[i][2];
      o = '0;
      o.a0 = 9'h1FF;
      o.b0 = 9'(9'h002 + i);
      o.sgn = i[1];
      // Product kept at 18 bits, as the element hands it over
      p = ext(o.a0, o.sgn) * ext(o.b0, o.sgn);
      // Set taken at the first edge; cycle k is k cycles after the offer
      i_op <= o;
      i_op_valid <= 1'b1;
      for (int k = 0; k <= n; k++)
      begin
        @(negedge i_clock);
        chk(o_mul_valid, (k == n) ? 1 : 0, "mul valid");
        if (k == n)
          chk(o_mul_prod, {14'h0, p}, "prod");
        @(posedge i_clock);
        i_op_valid <= 1'b0;
      end
      @(posedge i_clock);
    end
  endtask : t_mul

  // Back-to-back sets mixing sign, sum/difference and acc direction
  task t_dual();
    dme_pkg::dme_op_s o[4];
    wr(8'h00, 32'h200);
    wr(8'h04, 32'h1);
    acc_m = 32'h0;
    repeat (4) @(posedge i_clock);
    fab.got_q.delete();
    for (int i = 0; i < 4; i++)
    begin
      o[i] = {9'(9'h180 + i), 9'h07F, 9'h1F0, 9'(9'h0C3 - i), i[0], i[1],
              i[1] ^ i[0]};
      send(o[i]);
    end
    i_op_valid <= 1'b0;
    repeat (6) @(posedge i_clock);
    chk(fab.got_q.size(), 32'h4, "dual count");
    foreach (o[i])
    begin
      acc_step(o[i]);
      chk(fab.got_q[i].sum, dsum(o[i]), "dual sum");
      chk(fab.got_q[i].acc, acc_m, "acc value");
    end
    rd(8'h0C);
    chk(rd_v, acc_m, "acc reg");
  endtask : t_dual

  // All three dual stages on: result leaves the last stage after 3, enters the buffer and is visible after 4
  task t_dual_lat();
    dme_pkg::dme_op_s o;
    wr(8'h00, 32'h70);
    o = {9'h0FF, 9'h0FF, 9'h001, 9'h001, 1'b0, 1'b1, 1'b0};
    send(o);
    i_op_valid <= 1'b0;
    for (int k = 1; k <= 4; k++)
    begin
      @(negedge i_clock);
      chk(o_res_valid, (k == 4) ? 1 : 0, "dual latency");
      // Judged while the word stands, before the sink takes it
      if (k == 4)
        chk(o_res.sum, dsum(o), "piped sum");
      @(posedge i_clock);
    end
    repeat (3) @(posedge i_clock);
  endtask : t_dual_lat

  // Word-serial loading on the first lane, then back to parallel
  task t_serial();
    dme_pkg::dme_op_s o, w;
    wr(8'h00, 32'h100);
    fab.got_q.delete();
    o = {9'h1FE, 9'h005, 9'h003, 9'h1FD, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      w = o;
      w.a0 = o[38 - 9 * i -: 9];
      send(w);
      // Pause mid-group: the phase must show two words taken
      if (i == 1)
      begin
        i_op_valid <= 1'b0;
        rd(8'h08);
        chk(rd_v[9:8], 32'h2, "serial phase");
      end
    end
    i_op_valid <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk(fab.got_q.size(), 32'h1, "serial count");
    chk(fab.got_q[0].sum, dsum(o), "serial sum");
    wr(8'h00, 32'h0);
  endtask : t_serial

  // Stalled sink: buffer fills to 16, refuses, then drains in order
  task t_fill();
    dme_pkg::dme_op_s o;
    stall <= 1'b1;
    @(posedge i_clock);
    fab.got_q.delete();
    for (int i = 0; i < 16; i++)
    begin
      o = {9'(i), 9'h003, 9'h000, 9'h000, 1'b0, 1'b0, 1'b0};
      send(o);
    end
    @(negedge i_clock);
    chk(o_op_ready, 32'h0, "full refuse");
    @(posedge i_clock);
    i_op_valid <= 1'b0;
    rd(8'h08);
    chk(rd_v[4:0], 32'h10, "stat full");
    stall <= 1'b0;
    repeat (24) @(posedge i_clock);
    chk(fab.got_q.size(), 32'h10, "drained");
    chk(fab.got_q[15].sum, 19'h2D, "last word");
    rd(8'h08);
    chk(rd_v[4:0], 32'h0, "stat empty");
  endtask : t_fill

  task results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  initial
  begin
    repeat (8) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    t_regs();
    t_mul();
    t_dual();
    t_dual_lat();
    t_serial();
    t_fill();
    results();
  end
endmodule : tb
